// ===== dsp_ctrl_regs.vh
// constants for the dual converter serial readout and power-mode control
// assumes edge counts are compared against a 6-bit falling-edge counter
`ifndef DSP_CTRL_REGS_VH
`define DSP_CTRL_REGS_VH

// result format: straight binary, one step per lsb
`define DSP_RES_BITS      14
`define DSP_CODE_MIN      14'h0000
`define DSP_CODE_MAX      14'h3fff

// serial clock falling-edge counts within one frame
`define DSP_EDGE_GLITCH   6'h02
`define DSP_EDGE_STAY     6'h0a
`define DSP_EDGE_FIRST_DB 6'h02
`define DSP_EDGE_LAST_DB  6'h0f
`define DSP_EDGE_RESULT   6'h10
`define DSP_EDGE_OTHER_LO 6'h12
`define DSP_EDGE_OTHER_HI 6'h1f
`define DSP_EDGE_END      6'h20

// power modes
`define DSP_MODE_NORMAL   2'h0
`define DSP_MODE_PARTIAL  2'h1
`define DSP_MODE_FULL     2'h2

`endif

// ===== dsp_sync.v
// three-stage pin synchroniser with a debounced level and edge pulses
// assumes the pin is asynchronous to clk; edges are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

module dsp_sync #(
    parameter IDLE = 1'b1
) (
    input  wire clk,      // system clock
    input  wire rst_n,    // synchronous reset, active low
    input  wire pin_in,   // asynchronous pin
    output reg  level,    // settled level
    output reg  rise,     // one-cycle pulse on settled rise
    output reg  fall      // one-cycle pulse on settled fall
);

    reg s1_q;
    reg s2_q;
    reg s3_q;

    // first stage feeds only the second; change counts once stages 2 and 3 agree
    always @(posedge clk) begin
        if (!rst_n) begin
            s1_q  <= IDLE;
            s2_q  <= IDLE;
            s3_q  <= IDLE;
            level <= IDLE;
            rise  <= 1'b0;
            fall  <= 1'b0;
        end else begin
            s1_q  <= pin_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            rise  <= 1'b0;
            fall  <= 1'b0;
            if (s2_q == s3_q && s3_q != level) begin
                level <= s3_q;
                rise  <= s3_q;
                fall  <= ~s3_q;
            end
        end
    end

endmodule

`default_nettype wire

// ===== dsp_ctrl.v
// frame-select driven readout and power-mode control of a dual converter
// assumes the front end presents both 14-bit codes; serial pins are async
`timescale 1ns/1ps
`default_nettype none
`include "dsp_ctrl_regs.vh"

// What this block does
// RQ1: each result is a 14-bit straight binary code from 0 to 16383.
// RQ2: serial clock alone shifts result bits and steps both converters.
// RQ3: frame-select falling edge samples both channels and starts conversion.
// RQ4: host holds frame-select low for at least 10 falling edges for normal mode.
// RQ5: rise between edges 10 and 16 keeps power, abandons result, floats outputs.
// RQ6: sixteen serial clocks in one frame give one valid result.
// RQ7: after edge 16 outputs keep driving until frame-select rises or edge 32.
// RQ8: two more clocks after the result shift out two zero bits.
// RQ9: a further fourteen clocks shift out the other converter's result.
// RQ10: active output floats at edge 32 or frame-select rise, whichever first.
// RQ11: host waits for floated outputs, quiet interval and acquisition time.
// RQ12: normal mode, rise between edges 2 and 10 enters partial power-down.
// RQ13: normal mode, rise before edge 2 stays normal to reject glitches.
// RQ14: partial power-down, falling edge begins power-up, kept past edge 10.
// RQ15: partial power-down, rise before edge 2 returns to partial power-down.
// RQ16: partial power-down, rise between edges 2 and 10 enters full power-down.
// RQ17: leading zero at frame start, second zero, then 14 bits, last at edge 16.
// RQ18: frame-select fall drives outputs; its rise floats them and ends conversion.
// RQ19: full power-down exits by the same dummy frame held past edge 10.
// RQ20: edge counter clears per frame; mode and count decide at frame-select rise.
module dsp_ctrl (
    input  wire                      clk,            // 25 MHz system clock
    input  wire                      rst_n,          // synchronous reset, active low
    input  wire                      cs_n_pin,       // frame select pin, active low
    input  wire                      sclk_pin,       // host serial clock pin
    input  wire [`DSP_RES_BITS-1:0]  sample_a,       // code of converter a
    input  wire [`DSP_RES_BITS-1:0]  sample_b,       // code of converter b
    output reg                       data_out_a,     // serial data a
    output reg                       data_out_a_oe,  // drive enable of data a
    output reg                       data_out_b,     // serial data b
    output reg                       data_out_b_oe,  // drive enable of data b
    output reg  [1:0]                power_mode,     // current power mode
    output reg                       powering_up,    // dummy frame in progress
    output reg                       track_hold,     // high while holding sample
    output reg                       result_valid    // pulse at 16th edge, normal frame
);

    wire cs_level;
    wire cs_rise;
    wire cs_fall;
    wire sclk_rise;
    wire sclk_fall;

    reg  [`DSP_RES_BITS-1:0] cap_a_q;
    reg  [`DSP_RES_BITS-1:0] cap_b_q;
    reg  [5:0]               cnt_q;
    reg  [5:0]               cnt_d;
    reg                      in_frame_q;
    reg                      frame_normal_q;
    reg  [1:0]               mode_d;

    // frame select idles high
    dsp_sync #(.IDLE(1'b1)) u_cs (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in (cs_n_pin),
        .level  (cs_level),
        .rise   (cs_rise),
        .fall   (cs_fall)
    );

    // serial clock idle taken as low so an idle-high host sees no false fall
    dsp_sync #(.IDLE(1'b0)) u_sclk (
        .clk    (clk),
        .rst_n  (rst_n),
        .pin_in (sclk_pin),
        .level  (),
        .rise   (sclk_rise),
        .fall   (sclk_fall)
    );

    // bit shown after falling edge n: zeros, own code, two zeros, other code
    function pick_bit;
        input [5:0]               n;
        input [`DSP_RES_BITS-1:0] own;
        input [`DSP_RES_BITS-1:0] other;
        reg   [5:0]               idx;
        begin
            idx      = 6'h00;
            pick_bit = 1'b0;
            if (n >= `DSP_EDGE_FIRST_DB && n <= `DSP_EDGE_LAST_DB) begin
                idx      = `DSP_EDGE_LAST_DB - n; // RQ17
                pick_bit = own[idx[3:0]];
            end else if (n >= `DSP_EDGE_OTHER_LO && n <= `DSP_EDGE_OTHER_HI) begin
                idx      = `DSP_EDGE_OTHER_HI - n; // RQ9
                pick_bit = other[idx[3:0]];
            end
        end
    endfunction

    // next power mode chosen from mode and edge count at frame end
    always @* begin
        mode_d = power_mode;
        if (cnt_q >= `DSP_EDGE_STAY) begin
            mode_d = `DSP_MODE_NORMAL; // RQ5 RQ14 RQ19
        end else if (cnt_q >= `DSP_EDGE_GLITCH) begin
            if (power_mode == `DSP_MODE_NORMAL) begin
                mode_d = `DSP_MODE_PARTIAL; // RQ12
            end else begin
                mode_d = `DSP_MODE_FULL; // RQ16
            end
        end else begin
            mode_d = power_mode; // RQ13 RQ15
        end
    end

    // edge count after this falling edge; saturates at the end of the dual read
    always @* begin
        cnt_d = cnt_q;
        if (cnt_q != `DSP_EDGE_END) begin
            cnt_d = cnt_q + 6'h01;
        end
    end

    // frame engine: only serial clock edges advance the conversion
    always @(posedge clk) begin
        if (!rst_n) begin
            cap_a_q        <= `DSP_CODE_MIN;
            cap_b_q        <= `DSP_CODE_MIN;
            cnt_q          <= 6'h00;
            in_frame_q     <= 1'b0;
            frame_normal_q <= 1'b0;
            data_out_a     <= 1'b0;
            data_out_a_oe  <= 1'b0;
            data_out_b     <= 1'b0;
            data_out_b_oe  <= 1'b0;
            power_mode     <= `DSP_MODE_NORMAL;
            powering_up    <= 1'b0;
            track_hold     <= 1'b0;
            result_valid   <= 1'b0;
        end else begin
            result_valid <= 1'b0;
            if (cs_fall) begin
                cap_a_q        <= sample_a; // RQ1 RQ3
                cap_b_q        <= sample_b; // RQ3
                cnt_q          <= 6'h00; // RQ20
                in_frame_q     <= 1'b1;
                frame_normal_q <= (power_mode == `DSP_MODE_NORMAL);
                powering_up    <= (power_mode != `DSP_MODE_NORMAL); // RQ14 RQ19
                track_hold     <= 1'b1; // RQ3
                data_out_a     <= 1'b0; // RQ17
                data_out_b     <= 1'b0;
                data_out_a_oe  <= 1'b1; // RQ18
                data_out_b_oe  <= 1'b1; // RQ18
            end else if (cs_rise && in_frame_q) begin
                in_frame_q    <= 1'b0;
                power_mode    <= mode_d; // RQ20
                powering_up   <= 1'b0;
                track_hold    <= 1'b0;
                data_out_a    <= 1'b0;
                data_out_b    <= 1'b0;
                data_out_a_oe <= 1'b0; // RQ5 RQ10 RQ12 RQ18
                data_out_b_oe <= 1'b0; // RQ18
            end else if (in_frame_q) begin
                if (sclk_fall && cnt_q != `DSP_EDGE_END) begin
                    cnt_q      <= cnt_d; // RQ2
                    data_out_a <= pick_bit(cnt_d, cap_a_q, cap_b_q); // RQ2 RQ8
                    data_out_b <= pick_bit(cnt_d, cap_b_q, cap_a_q); // RQ9
                    // outputs stay driven past the result until edge 32
                    if (cnt_d == `DSP_EDGE_END) begin
                        data_out_a_oe <= 1'b0; // RQ7 RQ10
                        data_out_b_oe <= 1'b0; // RQ10
                    end
                    // dummy frames give no usable code
                    if (cnt_d == `DSP_EDGE_RESULT && frame_normal_q) begin
                        result_valid <= 1'b1; // RQ6
                    end
                end
                // back to track on the rising edge after the 15th fall
                if (sclk_rise && cnt_q >= `DSP_EDGE_LAST_DB) begin
                    track_hold <= 1'b0;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ===== dsp_ctrl_chk.sv
// concurrent checks on the frame readout and power-mode ports
// assumes bind into dsp_ctrl; single clk domain, reset synchronous low
`timescale 1ns/1ps
`default_nettype none
`include "dsp_ctrl_regs.vh"
module dsp_ctrl_chk (
    input wire logic       clk,           // system clock
    input wire logic       rst_n,         // reset, active low
    input wire logic       data_out_a,    // serial data a
    input wire logic       data_out_a_oe, // drive enable a
    input wire logic       data_out_b_oe, // drive enable b
    input wire logic [1:0] power_mode,    // power mode
    input wire logic       powering_up,   // dummy frame flag
    input wire logic       track_hold,    // hold flag
    input wire logic       result_valid   // result pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // both lines float and drive together
    oe_pair_a: assert property (data_out_a_oe == data_out_b_oe) else $error("enables differ");
    mode_legal_a: assert property (power_mode != 2'h3) else $error("bad mode");
    // mode may only move once the frame has ended
    mode_frame_a: assert property (data_out_a_oe && $past(data_out_a_oe) |-> $stable(power_mode))
        else $error("mode moved in frame");
    no_skip_a: assert property ($past(power_mode) == `DSP_MODE_NORMAL |-> power_mode != `DSP_MODE_FULL)
        else $error("normal to full");
    valid_pulse_a: assert property (result_valid |=> !result_valid) else $error("long valid");
    valid_normal_a: assert property (result_valid |-> power_mode == `DSP_MODE_NORMAL
        && !powering_up && data_out_a_oe) else $error("valid out of normal frame");
    pu_mode_a: assert property (powering_up |-> power_mode != `DSP_MODE_NORMAL)
        else $error("power-up in normal");
    start_hold_a: assert property ($rose(data_out_a_oe) |-> track_hold && !data_out_a)
        else $error("bad frame start");
    hold_end_a: assert property ($fell(data_out_a_oe) |-> !track_hold) else $error("hold kept");
    cover property (result_valid);
    cover property (power_mode == `DSP_MODE_FULL);
    cover property (powering_up);
    cover property ($fell(track_hold) && data_out_a_oe);
endmodule
bind dsp_ctrl dsp_ctrl_chk i_chk (.*);
`default_nettype wire

// ===== dsp_host_model.sv
// host serial port: frames of frame-select and serial clock, samples lines
// assumes 25 MHz clk; serial clock half period of four clk, still between frames
`timescale 1ns/1ps
`default_nettype none
module dsp_host_model (
    input  wire logic       clk,           // system clock
    input  wire logic       data_out_a,    // serial data a
    input  wire logic       data_out_a_oe, // drive enable a
    input  wire logic       data_out_b,    // serial data b
    input  wire logic       data_out_b_oe, // drive enable b
    output logic            cs_n_pin,      // frame select, active low
    output logic            sclk_pin,      // serial clock
    output logic [3:0]      rx,            // sampled enables and data
    output logic            rx_stb         // rises when rx is new
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        rx = 4'h0;
        rx_stb = 1'b0;
    end
    task automatic half();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // one frame of n falls; a floated line reads low, as enables gate the data
    task automatic frame(input int n);
        cs_n_pin = 1'b0;
        for (int k = 0; k <= n; k++) begin
            half();
            if (k < n) sclk_pin = 1'b1;
            rx_stb = 1'b0;
            half();
            rx = {data_out_a_oe, data_out_a & data_out_a_oe, data_out_b_oe, data_out_b & data_out_b_oe};
            rx_stb = 1'b1;
            sclk_pin = 1'b0;
        end
        half();
        rx_stb = 1'b0;
        cs_n_pin = 1'b1;
        // quiet time before any new frame
        repeat (25) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// self-checking bench: frames of varied length through the host model
// assumes dsp_ctrl, dsp_host_model and the bound checker are compiled
`timescale 1ns/1ps
`default_nettype none
`include "dsp_ctrl_regs.vh"
module tb_top;
    logic        clk, rst_n, cs_n_pin, sclk_pin, rx_stb;
    logic        data_out_a, data_out_a_oe, data_out_b, data_out_b_oe;
    logic        powering_up, track_hold, result_valid;
    logic [13:0] sample_a, sample_b;
    logic [1:0]  power_mode;
    logic [3:0]  rx;
    logic [3:0]  exp_q[$];
    int          fail_count = 0;
    int          compares = 0;
    int          valid_seen = 0;
    dsp_ctrl i_dsp_ctrl (.*);
    dsp_host_model i_dsp_host_model (.*);
    task automatic check(input logic [3:0] seen, input logic [3:0] want);
        compares++;
        if (seen !== want) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d, fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // expected {oe_a, a, oe_b, b} after k falls
    function automatic logic [3:0] exp_bits(input int k, input logic [13:0] a, input logic [13:0] b);
        if (k >= 32) return 4'h0;
        if (k < 2 || k == 16 || k == 17) return 4'ha;
        if (k < 16) return {1'b1, a[15-k], 1'b1, b[15-k]};
        return {1'b1, b[31-k], 1'b1, a[31-k]};
    endfunction
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // oldest note against each sampled bit
    always @(posedge rx_stb) check(rx, exp_q.pop_front());
    // result pulses counted; only a full frame begun in normal mode may raise one
    always @(posedge clk) if (result_valid === 1'b1) valid_seen++;
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    initial begin
        int         ns[9] = '{32, 10, 1, 2, 1, 12, 9, 9, 16};
        logic [1:0] ms[9] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0};
        rst_n = 1'b0;
        sample_a = 14'h0000;
        sample_b = 14'h0000;
        void'($urandom(60));
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        check({2'h0, power_mode}, 4'h0);
        // lengths hit both normal-mode window boundaries from each side; partial mode gets 1, 9 and 12, full mode only 16
        for (int t = 0; t < 9; t++) begin
            sample_a = (t == 0) ? `DSP_CODE_MAX : 14'($urandom);
            sample_b = (t == 1) ? `DSP_CODE_MIN : 14'($urandom);
            for (int k = 0; k <= ns[t]; k++) exp_q.push_back(exp_bits(k, sample_a, sample_b));
            i_dsp_host_model.frame(ns[t]);
            check({data_out_a_oe, data_out_b_oe, power_mode}, {2'h0, ms[t]});
            $display("test %0d done, %0d falls", t, ns[t]);
        end
        check(4'(exp_q.size()), 4'h0);
        check(4'(valid_seen), 4'h1);
        finish_test();
    end
endmodule
`default_nettype wire
